//--- src/crs_map.vh
`ifndef CRS_MAP_VH
`define CRS_MAP_VH
// register widths and reset values
`define CRS_SP_RESET     16'h017f
`define CRS_SP_HIGH      9'h002
`define CRS_FLAG_RESET   8'he8
`define CRS_FLAG_FIXED   8'he0
// flag bit positions
`define CRS_BIT_NIB      4
`define CRS_BIT_MASK     3
`define CRS_BIT_MSB      2
`define CRS_BIT_ZERO     1
`define CRS_BIT_OVF      0
// operation codes on op_in
`define CRS_OP_NONE      5'h00
`define CRS_OP_ADD       5'h01
`define CRS_OP_ADC       5'h02
`define CRS_OP_SUB       5'h03
`define CRS_OP_AND       5'h04
`define CRS_OP_OR        5'h05
`define CRS_OP_LDA       5'h06
`define CRS_OP_LDX       5'h07
`define CRS_OP_LDY       5'h08
`define CRS_OP_SHL       5'h09
`define CRS_OP_ROR       5'h0a
`define CRS_OP_BTST      5'h0b
`define CRS_OP_SCF       5'h0c
`define CRS_OP_RCF       5'h0d
`define CRS_OP_SIM       5'h0e
`define CRS_OP_RIM       5'h0f
`define CRS_OP_RSP       5'h10
`define CRS_OP_LDS       5'h11
`define CRS_OP_PUSHF     5'h12
`define CRS_OP_POPF      5'h13
`define CRS_OP_CALL      5'h14
`define CRS_OP_RET       5'h15
`define CRS_OP_INT       5'h16
`define CRS_OP_HANDLER_RETURN      5'h17
`define CRS_OP_JUMP      5'h18
`define CRS_OP_STEP      5'h19
`define CRS_OP_TRAP      5'h1a
// frame lengths in bytes
`define CRS_CALL_LEN     3'h2
`define CRS_INT_LEN      3'h5
`endif

//--- src/crs_core_regs.v
`timescale 1ns/1ps
`include "crs_map.vh"
// register set of the processor core
// accumulator, two index, fetch pointer,
// flags and stack pointer with its frames
// registers are reached by op codes only
// not through any memory map
// stack memory sits outside, on the mem ports
// Operation
// - 8-bit work register holds ALU results
// - two 8-bit index registers
// - interrupt frames never save second index
// - 16-bit fetch pointer, low and high bytes
// - flags: top three ones, reset 111x1xxx
// - nibble carry from bit 3 on adds
// - mask set on entry/set op, cleared unmask
// - masked requests stay pending until unmasked
// - unmask in handler takes pending; return restores
// - msb copy tracks result bit 7
// - zero flag tracks result zero
// - overflow bit: arithmetic, set/clear, shifts, tests
// - stack pointer resets/reloads to 017f
// - push then decrement, increment then pop
// - only seven low pointer bits vary
// - stack wraps silently at both limits
// - seven low pointer bits loadable and readable
// - interrupt frame starts with fetch low
// - call two bytes, interrupt five bytes
module crs_core_regs (
  input  wire        clk_in,        // core clock
  input  wire        reset_n_in,    // synchronous reset, active low
  input  wire [4:0]  op_in,         // operation code, one-cycle strobe
  input  wire [7:0]  operand_in,    // second operand or load data
  input  wire [15:0] target_in,     // jump, call or vector address
  input  wire        irq_in,        // interrupt request pulse
  input  wire [7:0]  mem_rdata_in,  // stack read data, same cycle
  output reg  [7:0]  work_out,      // work register
  output reg  [7:0]  first_idx_out, // first index register
  output reg  [7:0]  second_idx_out,// second index register
  output reg  [15:0] fetch_ptr_out, // fetch pointer
  output reg  [7:0]  flags_out,     // flag register
  output reg  [15:0] stack_ptr_out, // stack pointer
  output reg         irq_pend_out,  // latched pending request
  output reg         irq_take_out,  // request accepted, one cycle
  output reg         busy_out,      // frame sequence running
  output reg         mem_we_out,    // stack write strobe
  output reg  [15:0] mem_addr_out,  // stack address
  output reg  [7:0]  mem_wdata_out  // stack write data
);

  ////////////////////////////////////////////////////////////////////////////
  // state encoding, one-hot
  // idle accepts one op per cycle
  // push writes one frame byte per cycle
  // pop reads one frame byte per cycle
  // frame length picks call or interrupt shape
  // busy_out high for the whole frame
  // ops arriving while busy are dropped
  // a pending unmasked request beats any op
  // the request wins over the op offered
  // in that same cycle, which is then lost
  // callers must wait for busy low first
  // and for the pending latch to settle
  // before offering the next op
  localparam ST_IDLE = 3'b001;      // waiting for operations
  localparam ST_PUSH = 3'b010;      // writing a frame
  localparam ST_POP  = 3'b100;      // reading a frame back

  reg [2:0]  state;                 // sequencer state
  reg [2:0]  step;                  // byte index in frame
  reg [2:0]  frame_len;             // bytes in current frame
  reg        frame_int;             // frame is an interrupt frame
  reg [7:0]  ret_low;               // unused, only cleared at reset
  reg [7:0]  nib_sum;               // low nibble sum helper
  reg [8:0]  full_sum;              // nine bit sum helper
  reg [7:0]  result;                // result of current op
  reg        upd_nz;                // op updates msb and zero flags
  reg [7:0]  frame_byte;            // byte to push at step
  reg [15:0] sp_dec;                // pointer after one push
  reg [15:0] sp_inc;                // pointer before one pop

  ////////////////////////////////////////////////////////////////////////////
  // pointer arithmetic confined to seven bits
  // the stack is 128 bytes, so only the
  // seven low pointer bits ever count
  // the upper nine bits are a constant
  // subtraction below zero wraps to 7f
  // addition above 7f wraps to zero
  // no overflow or underflow flag exists
  // old bytes are overwritten silently
  // sp_dec is the pointer after a push
  // sp_inc is the pointer before a pop
  // both are pure wiring, no state
  always @* begin
    sp_dec = {`CRS_SP_HIGH, stack_ptr_out[6:0] - 7'h01};
    sp_inc = {`CRS_SP_HIGH, stack_ptr_out[6:0] + 7'h01};
  end

  ////////////////////////////////////////////////////////////////////////////
  // alu result for flag updates
  // one shared adder serves add and subtract
  // bit 8 of full_sum is carry or borrow
  // nib_sum bit 4 is the low nibble carry
  // logic ops and loads pass through
  // shifts reuse full_sum as a shifter
  // rotate pulls the carry into bit 7
  // upd_nz tells the main process
  // whether msb and zero follow this op
  // ops with no result leave them alone
  // only meaningful while idle
  always @* begin
    nib_sum  = 8'h00;
    full_sum = 9'h000;
    result   = 8'h00;
    upd_nz   = 1'b1;
    case (op_in)
      `CRS_OP_ADD: begin
        full_sum = {1'b0, work_out} + {1'b0, operand_in};
        nib_sum  = {4'h0, work_out[3:0]} + {4'h0, operand_in[3:0]};
      end
      `CRS_OP_ADC: begin
        full_sum = {1'b0, work_out} + {1'b0, operand_in} + {8'h00, flags_out[`CRS_BIT_OVF]};
        nib_sum  = {4'h0, work_out[3:0]} + {4'h0, operand_in[3:0]}
                   + {7'h00, flags_out[`CRS_BIT_OVF]};
      end
      `CRS_OP_SUB: full_sum = {1'b0, work_out} - {1'b0, operand_in};
      `CRS_OP_AND: full_sum = {1'b0, work_out & operand_in};
      `CRS_OP_OR:  full_sum = {1'b0, work_out | operand_in};
      `CRS_OP_LDA, `CRS_OP_LDX, `CRS_OP_LDY: full_sum = {1'b0, operand_in};
      `CRS_OP_SHL: full_sum = {work_out, 1'b0};
      `CRS_OP_ROR: full_sum = {1'b0, flags_out[`CRS_BIT_OVF], work_out[7:1]};
      default:     upd_nz = 1'b0;
    endcase
    result = full_sum[7:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // byte pushed at each frame step
  // step counts from zero upward on push
  // call frames stop after the high byte
  // interrupt frames go on to index,
  // work register and then the flags
  // second index is never part of it
  // pop walks the same steps downward
  // so the last byte pushed comes first
  always @* begin
    case (step)
      3'h0:    frame_byte = fetch_ptr_out[7:0];
      3'h1:    frame_byte = fetch_ptr_out[15:8];
      3'h2:    frame_byte = first_idx_out;
      3'h3:    frame_byte = work_out;
      default: frame_byte = flags_out;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // main register process
  // every register lives in this process
  // so each has exactly one driver
  // reset is synchronous and level based
  // undefined reset flag bits come up zero
  // write strobe and take pulse default low
  // and stay high only in cycles that set them
  // the pending latch is set by irq_in
  // and the set wins over a clear
  // the last statement pins the upper
  // pointer bits after any assignment
  // frame sequences take several cycles
  // register ops take exactly one
  // flags change only on the ops that
  // the flag rules name
  always @(posedge clk_in) begin
    if (!reset_n_in) begin
      work_out       <= 8'h00;
      first_idx_out  <= 8'h00;
      second_idx_out <= 8'h00;
      fetch_ptr_out  <= 16'h0000;
      flags_out      <= `CRS_FLAG_RESET;
      stack_ptr_out  <= `CRS_SP_RESET;
      irq_pend_out   <= 1'b0;
      irq_take_out   <= 1'b0;
      busy_out       <= 1'b0;
      mem_we_out     <= 1'b0;
      mem_addr_out   <= `CRS_SP_RESET;
      mem_wdata_out  <= 8'h00;
      state          <= ST_IDLE;
      step           <= 3'h0;
      frame_len      <= 3'h0;
      frame_int      <= 1'b0;
      ret_low        <= 8'h00;
    end else begin
      mem_we_out   <= 1'b0;
      irq_take_out <= 1'b0;
      // request latched, set wins over service
      if (irq_in)
        irq_pend_out <= 1'b1;
      case (state)
        ST_IDLE: begin
          mem_addr_out <= stack_ptr_out;
          // address tracks the pointer while idle
          // so a flag push writes the right byte
          // interrupt service comes first
          // op decode only when nothing is taken
          if (irq_pend_out && !flags_out[`CRS_BIT_MASK]) begin
            // pending taken as soon as mask drops, any level
            irq_pend_out <= irq_in;
            irq_take_out <= 1'b1;
            frame_int    <= 1'b1;
            frame_len    <= `CRS_INT_LEN;
            step         <= 3'h0;
            busy_out     <= 1'b1;
            state        <= ST_PUSH;
          end else begin
            case (op_in)
              `CRS_OP_ADD, `CRS_OP_ADC: begin
                work_out <= result;
                flags_out[`CRS_BIT_NIB] <= nib_sum[4];
                flags_out[`CRS_BIT_OVF] <= full_sum[8];
              end
              `CRS_OP_SUB, `CRS_OP_SHL: begin
                work_out <= result;
                flags_out[`CRS_BIT_OVF] <= full_sum[8];
              end
              `CRS_OP_ROR: begin
                work_out <= result;
                flags_out[`CRS_BIT_OVF] <= work_out[0];
              end
              `CRS_OP_AND, `CRS_OP_OR, `CRS_OP_LDA: work_out <= result;
              `CRS_OP_LDX: first_idx_out  <= operand_in;
              `CRS_OP_LDY: second_idx_out <= operand_in;
              `CRS_OP_BTST: flags_out[`CRS_BIT_OVF] <= operand_in[0];
              `CRS_OP_SCF: flags_out[`CRS_BIT_OVF] <= 1'b1;
              `CRS_OP_RCF: flags_out[`CRS_BIT_OVF] <= 1'b0;
              `CRS_OP_SIM: flags_out[`CRS_BIT_MASK] <= 1'b1;
              `CRS_OP_RIM: flags_out[`CRS_BIT_MASK] <= 1'b0;
              `CRS_OP_RSP: stack_ptr_out <= `CRS_SP_RESET;
              `CRS_OP_LDS: stack_ptr_out <= {`CRS_SP_HIGH, operand_in[6:0]};
              `CRS_OP_JUMP: fetch_ptr_out <= target_in;
              `CRS_OP_STEP: fetch_ptr_out <= fetch_ptr_out + 16'h0001;
              `CRS_OP_PUSHF: begin
                // push the flags as one byte
                mem_we_out    <= 1'b1;
                mem_wdata_out <= flags_out;
                stack_ptr_out <= sp_dec;
              end
              `CRS_OP_POPF: begin
                // pop needs the incremented address first
                frame_len    <= 3'h1;
                frame_int    <= 1'b0;
                step         <= 3'h4;
                mem_addr_out <= sp_inc;
                stack_ptr_out <= sp_inc;
                busy_out     <= 1'b1;
                state        <= ST_POP;
              end
              `CRS_OP_CALL, `CRS_OP_INT, `CRS_OP_TRAP: begin
                // trap enters even while masked
                frame_int <= (op_in != `CRS_OP_CALL);
                frame_len <= (op_in == `CRS_OP_CALL) ? `CRS_CALL_LEN : `CRS_INT_LEN;
                step      <= 3'h0;
                busy_out  <= 1'b1;
                state     <= ST_PUSH;
              end
              `CRS_OP_RET, `CRS_OP_HANDLER_RETURN: begin
                frame_int <= (op_in == `CRS_OP_HANDLER_RETURN);
                frame_len <= (op_in == `CRS_OP_HANDLER_RETURN) ? `CRS_INT_LEN : `CRS_CALL_LEN;
                step      <= (op_in == `CRS_OP_HANDLER_RETURN) ? 3'h4 : 3'h1;
                mem_addr_out  <= sp_inc;
                stack_ptr_out <= sp_inc;
                busy_out  <= 1'b1;
                state     <= ST_POP;
              end
              default: begin
              end
            endcase
            // msb and zero flags follow every result
            if (upd_nz) begin
              flags_out[`CRS_BIT_MSB]  <= result[7];
              flags_out[`CRS_BIT_ZERO] <= (result == 8'h00);
            end
          end
        end
        ST_PUSH: begin
          // one byte per cycle, then decrement
          // address is the pointer before decrement
          // the write lands one cycle later
          // last step restores idle and loads
          // the vector or call target
          mem_we_out    <= 1'b1;
          mem_addr_out  <= stack_ptr_out;
          mem_wdata_out <= frame_byte;
          stack_ptr_out <= sp_dec;
          if (step == frame_len - 3'h1) begin
            if (frame_int)
              flags_out[`CRS_BIT_MASK] <= 1'b1;
            fetch_ptr_out <= target_in;
            busy_out      <= 1'b0;
            state         <= ST_IDLE;
          end else begin
            step <= step + 3'h1;
          end
        end
        ST_POP: begin
          // data at mem_addr_out arrives this cycle
          // step four is the flags byte
          // step zero is the fetch low byte
          // calls start at step one
          // flag pop keeps the top bits at one
          case (step)
            3'h4: flags_out <= mem_rdata_in | `CRS_FLAG_FIXED;
            3'h3: work_out  <= mem_rdata_in;
            3'h2: first_idx_out <= mem_rdata_in;
            3'h1: fetch_ptr_out[15:8] <= mem_rdata_in;
            default: fetch_ptr_out[7:0] <= mem_rdata_in;
          endcase
          if (step == 3'h0 || frame_len == 3'h1) begin
            busy_out     <= 1'b0;
            mem_addr_out <= stack_ptr_out;
            state        <= ST_IDLE;
          end else begin
            step          <= step - 3'h1;
            mem_addr_out  <= sp_inc;
            stack_ptr_out <= sp_inc;
          end
        end
        default: state <= ST_IDLE;
      endcase
      // upper pointer bits hold regardless of writes
      stack_ptr_out[15:7] <= `CRS_SP_HIGH;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // usage limits
  // memory read data must be valid in the
  // same cycle as mem_addr_out
  // the stack memory is outside this block
  // target_in must hold until frame end
  // irq_in may be a pulse or a level
  // a level retriggers after the return
  // trap ignores the mask on purpose
  // the plain interrupt op ignores it too
  // second index survives any interrupt
  // only software may save it

endmodule

//--- testbench/crs_core_regs_props.sv
`timescale 1ns/1ps
`include "crs_map.vh"
module crs_core_regs_props (
  input wire        clk_in,
  input wire        reset_n_in,
  input wire [4:0]  op_in,
  input wire [7:0]  operand_in,
  input wire [15:0] target_in,
  input wire        irq_in,
  input wire [7:0]  mem_rdata_in,
  input wire [7:0]  work_out,
  input wire [7:0]  first_idx_out,
  input wire [7:0]  second_idx_out,
  input wire [15:0] fetch_ptr_out,
  input wire [7:0]  flags_out,
  input wire [15:0] stack_ptr_out,
  input wire        irq_pend_out,
  input wire        irq_take_out,
  input wire        busy_out,
  input wire        mem_we_out,
  input wire [15:0] mem_addr_out,
  input wire [7:0]  mem_wdata_out
);
  // op accepted: idle and no unmasked request waiting
  wire acc = !busy_out && !(irq_pend_out && !flags_out[3]);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  chk_flag_ones: assert property (flags_out[7:5] == 3'b111)
    else $error("flag top bits not ones");
  chk_sp_upper: assert property (stack_ptr_out[15:7] == 9'h002)
    else $error("stack pointer upper bits moved");
  chk_sp_reload: assert property (acc && op_in == `CRS_OP_RSP |=>
    stack_ptr_out == 16'h017f) else $error("stack reload wrong");
  chk_nibble_carry: assert property (acc && op_in == `CRS_OP_ADD |=>
    flags_out[4] == (({1'b0, $past(work_out[3:0])}
    + {1'b0, $past(operand_in[3:0])}) > 5'h0f)) else $error("nibble carry wrong");
  chk_load_flags: assert property (acc && op_in == `CRS_OP_LDA |=>
    flags_out[2:1] == {$past(operand_in[7]), $past(operand_in) == 8'h00})
    else $error("sign or zero flag wrong");
  chk_pend_held: assert property (irq_pend_out && flags_out[3] && !busy_out
    |=> irq_pend_out) else $error("masked request lost");
  chk_take_unmasked: assert property (irq_pend_out && !flags_out[3]
    && !busy_out |=> irq_take_out) else $error("pending request not taken");
  chk_push_order: assert property (mem_we_out |->
    stack_ptr_out[6:0] == mem_addr_out[6:0] - 7'h01) else $error("push order wrong");
  chk_call_len: assert property (acc && op_in == `CRS_OP_CALL |-> ##3
    stack_ptr_out[6:0] == $past(stack_ptr_out[6:0], 3) - 7'h02)
    else $error("call frame length wrong");
  chk_mask_entry: assert property (irq_take_out |-> ##[1:8]
    (flags_out[3] && !busy_out)) else $error("mask not set on entry");
  cover property (irq_take_out);
  cover property (acc && op_in == `CRS_OP_CALL);
  cover property (mem_we_out ##1 mem_we_out);
endmodule

//--- testbench/crs_core_regs_test.sv
`timescale 1ns/1ps
`include "crs_map.vh"
module crs_core_regs_test;
  logic        clk_in, reset_n_in, irq_in, irq_pend_out, irq_take_out, busy_out, mem_we_out;
  logic [4:0]  op_in;
  logic [7:0]  operand_in, mem_rdata_in, work_out, first_idx_out, second_idx_out;
  logic [7:0]  flags_out, mem_wdata_out;
  logic [15:0] target_in, fetch_ptr_out, stack_ptr_out, mem_addr_out;
  logic [7:0]  mem [0:127];  // stack ram
  logic [7:0]  frame [5] = '{8'h34, 8'h12, 8'h5a, 8'h3c, 8'he0};
  int          bad_count, total_checks;
  crs_core_regs u_crs_core_regs (.*);
  assign mem_rdata_in = mem[mem_addr_out[6:0]];
  always @(posedge clk_in) if (mem_we_out) mem[mem_addr_out[6:0]] <= mem_wdata_out;
  task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task print_verdict;
    if (bad_count == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // one op strobe, then wait until idle with nothing about to be taken
  task run(input logic [4:0] op, input logic [7:0] val = 8'h00,
           input logic [15:0] tgt = 16'h0000);
    @(posedge clk_in);
    op_in <= op;
    operand_in <= val;
    target_in <= tgt;
    @(posedge clk_in);
    op_in <= `CRS_OP_NONE;
    for (int i = 0; i < 30; i++) begin
      @(posedge clk_in);
      #1;
      if (!busy_out && !irq_take_out && !mem_we_out && !(irq_pend_out && !flags_out[3]))
        return;
    end
    bad_count++;
    print_verdict;
  endtask
  // call from a given pointer and return
  task call_ret(input logic [7:0] s, input logic [6:0] a, input logic [6:0] b);
    run(`CRS_OP_LDS, s);
    check("sp", stack_ptr_out, {9'h002, s[6:0]});
    run(`CRS_OP_CALL, 8'h00, 16'habcd);
    check("lo", mem[a], 8'h34);
    check("hi", mem[b], 8'h12);
    check("sp", stack_ptr_out, {9'h002, b - 7'h01});
    check("pc", fetch_ptr_out, 16'habcd);
    run(`CRS_OP_RET);
    check("sp", stack_ptr_out, {9'h002, s[6:0]});
    check("pc", fetch_ptr_out, 16'h1234);
  endtask
  initial begin
    clk_in = 0;
    forever #2.5 clk_in = ~clk_in;
  end
  initial begin
    reset_n_in = 0;
    op_in = 0;
    operand_in = 0;
    target_in = 0;
    irq_in = 0;
    bad_count = 0;
    total_checks = 0;
    for (int i = 0; i < 128; i++) mem[i] = 8'h00;
    repeat (8) @(posedge clk_in);
    reset_n_in <= 1'b1;
    #1;
    check("flags", flags_out, 8'he8);
    check("sp", stack_ptr_out, 16'h017f);
    run(`CRS_OP_LDX, 8'h5a);
    run(`CRS_OP_LDY, 8'ha5);
    check("x", first_idx_out, 8'h5a);
    check("y", second_idx_out, 8'ha5);
    run(`CRS_OP_LDA, 8'h80);
    check("flags", flags_out, 8'hec);
    run(`CRS_OP_LDA, 8'h00);
    check("flags", flags_out, 8'hea);
    run(`CRS_OP_LDA, 8'h0f);
    run(`CRS_OP_ADD, 8'h01);
    check("flags", flags_out, 8'hf8);
    run(`CRS_OP_ADD, 8'h01);
    check("work", work_out, 8'h11);
    check("flags", flags_out, 8'he8);
    run(`CRS_OP_SCF);
    check("flags", flags_out, 8'he9);
    run(`CRS_OP_RCF);
    check("flags", flags_out, 8'he8);
    run(`CRS_OP_JUMP, 8'h00, 16'h1234);
    check("pc", fetch_ptr_out, 16'h1234);
    call_ret(8'h05, 7'h05, 7'h04);
    call_ret(8'h00, 7'h00, 7'h7f);
    run(`CRS_OP_RSP);
    check("sp", stack_ptr_out, 16'h017f);
    run(`CRS_OP_LDA, 8'h3c, 16'h4000);
    @(posedge clk_in);
    irq_in <= 1'b1;
    @(posedge clk_in);
    irq_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    #1;
    check("pend", {irq_pend_out, irq_take_out, busy_out}, 3'b100);
    run(`CRS_OP_RIM, 8'h00, 16'h4000);
    check("sp", stack_ptr_out, 16'h017a);
    check("pc", fetch_ptr_out, 16'h4000);
    check("flags", flags_out, 8'he8);
    for (int i = 0; i < 5; i++) check("frame", mem[7'h7f - i], frame[i]);
    run(`CRS_OP_LDY, 8'h11);
    run(`CRS_OP_LDA, 8'h00);
    run(`CRS_OP_HANDLER_RETURN);
    check("work", work_out, 8'h3c);
    check("x", first_idx_out, 8'h5a);
    check("y", second_idx_out, 8'h11);
    check("pc", fetch_ptr_out, 16'h1234);
    check("flags", flags_out, 8'he0);
    check("sp", stack_ptr_out, 16'h017f);
    run(`CRS_OP_SIM);
    check("flags", flags_out, 8'he8);
    run(`CRS_OP_STEP);
    check("pc", fetch_ptr_out, 16'h1235);
    run(`CRS_OP_LDA, 8'h81);
    run(`CRS_OP_SHL);
    check("work", work_out, 8'h02);
    check("flags", flags_out, 8'he9);
    run(`CRS_OP_ROR);
    check("work", work_out, 8'h81);
    check("flags", flags_out, 8'hec);
    run(`CRS_OP_ADC, 8'h7f);
    check("work", work_out, 8'h00);
    check("flags", flags_out, 8'hfb);
    run(`CRS_OP_SUB, 8'h01);
    check("work", work_out, 8'hff);
    check("flags", flags_out, 8'hfd);
    run(`CRS_OP_BTST, 8'h02);
    check("flags", flags_out, 8'hfc);
    run(`CRS_OP_AND, 8'h0f);
    check("flags", flags_out, 8'hf8);
    run(`CRS_OP_OR, 8'h80);
    check("work", work_out, 8'h8f);
    check("flags", flags_out, 8'hfc);
    run(`CRS_OP_PUSHF);
    check("sp", stack_ptr_out, 16'h017e);
    check("pushf", mem[7'h7f], 8'hfc);
    run(`CRS_OP_LDA, 8'h00);
    run(`CRS_OP_POPF);
    check("flags", flags_out, 8'hfc);
    check("sp", stack_ptr_out, 16'h017f);
    run(`CRS_OP_TRAP, 8'h00, 16'h5000);
    check("pc", fetch_ptr_out, 16'h5000);
    check("sp", stack_ptr_out, 16'h017a);
    check("trap", mem[7'h7f], 8'h35);
    run(`CRS_OP_HANDLER_RETURN);
    check("pc", fetch_ptr_out, 16'h1235);
    check("sp", stack_ptr_out, 16'h017f);
    print_verdict;
  end
endmodule
bind crs_core_regs crs_core_regs_props u_crs_core_regs_props (.*);
